/* File: idf_regs.svh */
// Word indices, fixed word values and reset values of the feature words
`ifndef IDF_REGS_SVH
`define IDF_REGS_SVH

// ----------------------------------------
// Word indices in the identification stream
// ----------------------------------------
`define IDF_IDX_DMA_RECOMMENDED_CYCLE  8'h42
`define IDF_IDX_PIO_MIN_CYCLE_NO_FLOW  8'h43
`define IDF_IDX_PIO_MIN_CYCLE_FLOW     8'h44
`define IDF_IDX_MAJOR_VERSION          8'h50
`define IDF_IDX_MINOR_VERSION          8'h51
`define IDF_IDX_FEATURES_SUPPORTED_A   8'h52
`define IDF_IDX_FEATURES_SUPPORTED_B   8'h53
`define IDF_IDX_FEATURES_SUPPORTED_C   8'h54
`define IDF_IDX_FEATURES_ENABLED_A     8'h55
`define IDF_IDX_FEATURES_ENABLED_B     8'h56
`define IDF_IDX_FEATURES_ENABLED_C     8'h57
`define IDF_IDX_APM_LEVEL              8'h5b

// ----------------------------------------
// Cycle times in nanoseconds
// ----------------------------------------
`define IDF_CYCLE_DEFAULT_NS           16'h0078
`define IDF_CYCLE_FAST_NS              16'h0050

// ----------------------------------------
// Fixed word values
// ----------------------------------------
`define IDF_MAJOR_VERSION_VAL          16'h00fe
`define IDF_MINOR_VERSION_VAL          16'h0021
`define IDF_SUPPORTED_A_VAL            16'h706b
`define IDF_SUPPORTED_B_VAL            16'h7408
`define IDF_SUPPORTED_C_VAL            16'h4000
`define IDF_ENABLED_A_FIXED            16'h0400
`define IDF_ENABLED_B_VAL              16'h3700
`define IDF_ENABLED_C_VAL              16'h4000
`define IDF_APM_LEVEL_VAL              16'h0000
`define IDF_UNMAPPED_VAL               16'h0000

// ----------------------------------------
// Enable state: bits that the command logic may change, and reset state
// ----------------------------------------
`define IDF_ENABLE_CHANGEABLE          16'h706a
`define IDF_ENABLE_RESET               16'h7068

`endif

/* File: idf_pkg.sv */
// Types shared by the identification feature word logic
package idf_pkg;

	typedef logic [15:0] idf_word_type;
	typedef logic [7:0]  idf_index_type;

endpackage : idf_pkg

/* File: idf_feature_words.sv */
// Identification words 66 to 91: cycle times, versions, feature words
`timescale 1ns/1ns
`include "idf_regs.svh"

module idf_feature_words (
	input  wire logic                  i_clk,
	input  wire logic                  i_reset,
	input  wire logic                  i_rd,
	input  wire idf_pkg::idf_index_type i_rd_idx,
	input  wire logic                  i_fast_cycle,
	input  wire idf_pkg::idf_word_type  i_feat_set,
	input  wire idf_pkg::idf_word_type  i_feat_clr,
	output logic                       o_rd_valid,
	output logic                       o_rd_hit,
	output idf_pkg::idf_word_type      o_rd_data,
	output logic                       o_pio_words_valid
);

	// ----------------------------------------
	// Feature enable state
	// ----------------------------------------
	idf_pkg::idf_word_type enable_r;
	idf_pkg::idf_word_type enable_nxt;
	idf_pkg::idf_word_type changeable;

	// Only bits the supported word marks as present may move
	assign changeable = `IDF_ENABLE_CHANGEABLE & `IDF_SUPPORTED_A_VAL;

	genvar b;
	generate
		for (b = 0; b < 16; b++) begin : g_enable
			always_comb begin
				if (!changeable[b]) begin
					enable_nxt[b] = enable_r[b];
				end else if (i_feat_set[b]) begin
					enable_nxt[b] = 1'b1;
				end else if (i_feat_clr[b]) begin
					enable_nxt[b] = 1'b0;
				end else begin
					enable_nxt[b] = enable_r[b];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			enable_r <= `IDF_ENABLE_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	// ----------------------------------------
	// Word selection
	// ----------------------------------------
	idf_pkg::idf_word_type cycle_time;
	idf_pkg::idf_word_type word_sel;
	logic                  hit_sel;

	// Reported rate is a ceiling hint; the device may still throttle
	assign cycle_time = i_fast_cycle ? `IDF_CYCLE_FAST_NS : `IDF_CYCLE_DEFAULT_NS;

	always_comb begin
		hit_sel = 1'b1;
		case (i_rd_idx)
			`IDF_IDX_DMA_RECOMMENDED_CYCLE: word_sel = cycle_time;
			`IDF_IDX_PIO_MIN_CYCLE_NO_FLOW: word_sel = cycle_time;
			`IDF_IDX_PIO_MIN_CYCLE_FLOW:    word_sel = cycle_time;
			`IDF_IDX_MAJOR_VERSION:         word_sel = `IDF_MAJOR_VERSION_VAL;
			`IDF_IDX_MINOR_VERSION:         word_sel = `IDF_MINOR_VERSION_VAL;
			`IDF_IDX_FEATURES_SUPPORTED_A:  word_sel = `IDF_SUPPORTED_A_VAL;
			`IDF_IDX_FEATURES_SUPPORTED_B:  word_sel = `IDF_SUPPORTED_B_VAL;
			`IDF_IDX_FEATURES_SUPPORTED_C:  word_sel = `IDF_SUPPORTED_C_VAL;
			`IDF_IDX_FEATURES_ENABLED_A:
				word_sel = (enable_r & changeable) | `IDF_ENABLED_A_FIXED;
			`IDF_IDX_FEATURES_ENABLED_B:    word_sel = `IDF_ENABLED_B_VAL;
			`IDF_IDX_FEATURES_ENABLED_C:    word_sel = `IDF_ENABLED_C_VAL;
			`IDF_IDX_APM_LEVEL:             word_sel = `IDF_APM_LEVEL_VAL;
			default: begin
				word_sel = `IDF_UNMAPPED_VAL;
				hit_sel  = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Registered read answer
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rd_valid <= 1'b0;
			o_rd_hit   <= 1'b0;
			o_rd_data  <= `IDF_UNMAPPED_VAL;
		end else begin
			o_rd_valid <= i_rd;
			o_rd_hit   <= i_rd & hit_sel;
			if (i_rd) begin
				o_rd_data <= word_sel;
			end
		end
	end

	// Cycle-time words are reported supported in every cycle after reset
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_pio_words_valid <= 1'b0;
		end else begin
			o_pio_words_valid <= 1'b1;
		end
	end

endmodule : idf_feature_words

/* File: idf_feature_words_asserts.sv */
// Assertions on the feature word read port
`timescale 1ns/1ns
module idf_feature_words_asserts (
	input logic        i_clk,
	input logic        i_reset,
	input logic        i_rd,
	input logic [7:0]  i_rd_idx,
	input logic        i_fast_cycle,
	input logic        o_rd_valid,
	input logic [15:0] o_rd_data,
	input logic        o_pio_words_valid
);
	wire logic [7:0] ri = i_rd ? i_rd_idx : 8'hff;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_read_answer: assert property (i_rd |=> o_rd_valid) else $error("no answer");
	a_dma_word: assert property (ri == 8'h42 && !i_fast_cycle |=> o_rd_data == 16'h0078)
		else $error("w66");
	a_pio_word: assert property (ri == 8'h43 |=>
		o_rd_data == ($past(i_fast_cycle) ? 16'h0050 : 16'h0078)) else $error("w67");
	a_major_word: assert property (ri == 8'h50 |=> &o_rd_data[6:1] && ~&o_rd_data)
		else $error("w80");
	a_minor_word: assert property (ri == 8'h51 |=> o_rd_data == 16'h0021) else $error("w81");
	a_supp_word: assert property (ri == 8'h52 |=> o_rd_data == 16'h706b)
		else $error("w82");
	a_enabled_fixed: assert property (ri == 8'h55 |=> (o_rd_data & 16'h8f95) == 16'h0400)
		else $error("w85");
	a_pio_valid: assert property (!$past(i_reset) |-> o_pio_words_valid)
		else $error("w53");
endmodule : idf_feature_words_asserts

/* File: idf_host.sv */
// Host model issuing single identification word reads
`timescale 1ns/1ns
module idf_host (
	input  logic       i_clk,
	output logic       o_rd,
	output logic [7:0] o_rd_idx
);
	initial {o_rd, o_rd_idx} = '0;
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk) {o_rd, o_rd_idx} <= {1'b1, a};
		@(posedge i_clk) {o_rd, o_rd_idx} <= {1'b0, ~a}; // Released index is driven to the inverse of the read index
	endtask : rd
endmodule : idf_host

/* File: test_idf_feature_words.sv */
// Bench for the identification feature word block
`timescale 1ns/1ns
module test_idf_feature_words;
	logic        i_clk = 1'b0, i_reset = 1'b1, i_fast_cycle = 1'b0, i_rd;
	logic        o_rd_valid, o_rd_hit, o_pio_words_valid;
	logic [7:0]  i_rd_idx;
	logic [15:0] i_feat_set = '0, i_feat_clr = '0, o_rd_data;
	int          n_fail = 0, cmp_count = 0;
	logic [23:0] tbl [13] = '{24'h420078, 24'h430078, 24'h440078, 24'h5000fe, 24'h510021,
		24'h52706b, 24'h537408, 24'h544000, 24'h557468, 24'h563700, 24'h574000, 24'h5b0000, 24'h0};
	always #25 i_clk = ~i_clk;
	idf_host host (.i_clk(i_clk), .o_rd(i_rd), .o_rd_idx(i_rd_idx));
	idf_feature_words dut (.*);
	task automatic chk(input logic [7:0] a, input logic [15:0] e, s, c);
		@(posedge i_clk) {i_feat_set, i_feat_clr} <= {s, c};
		@(posedge i_clk) {i_feat_set, i_feat_clr} <= '0;
		host.rd(a);
		#1;
		cmp_count++;
		if ({o_rd_data, o_rd_hit, o_rd_valid, o_pio_words_valid} !== {e, a != 8'h0, 2'b11}) begin
			n_fail++;
			$display("wrong value at %0t: word %h read %h", $time, a, o_rd_data);
		end
	endtask : chk
	task automatic print_verdict();
		$display("%0d checks, %0d wrong", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin
		#100000 n_fail++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		foreach (tbl[k]) chk(tbl[k][23:16], tbl[k][15:0], '0, '0);
		@(posedge i_clk) i_fast_cycle <= 1'b1;
		chk(8'h43, 16'h0050, '0, '0);
		chk(8'h42, 16'h0050, '0, '0);
		chk(8'h44, 16'h0050, '0, '0);
		chk(8'h53, 16'h7408, '0, '0);
		chk(8'h54, 16'h4000, '0, '0);
		chk(8'h57, 16'h4000, '0, '0);
		$display("cycle and version words done");
		chk(8'h55, 16'h7428, '0, 16'h0040);
		chk(8'h55, 16'h742a, 16'h8003, 16'h0400);
		chk(8'h55, 16'h744a, 16'h0040, 16'h0060);
		$display("feature enable words done");
		print_verdict();
	end
endmodule : test_idf_feature_words
bind idf_feature_words idf_feature_words_asserts u_chk (.*);
